/* hdl/ca_parity_alert_pkg.sv */
// constants for the command/address parity and alert block
// assumes one 50 MHz clock (pclk) and an apb master for the registers
package ca_parity_alert_pkg;
   localparam int CLK_MHZ = 50;
   // register byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_MASK = 12'h008;
   localparam logic [11:0] ADDR_INFO = 12'h00c;
   // control field positions
   localparam int CTRL_PL_LSB = 0;
   localparam int CTRL_PL_W = 3;
   localparam int CTRL_CRC_EN = 3;
   localparam logic [2:0] PL_DISABLED = 3'h0;
   // status / mask bit positions
   localparam int ST_CRC = 0;
   localparam int ST_PAR = 1;
   localparam int ST_W = 2;
   // info register bit positions
   localparam int INFO_ALERT = 0;
   localparam int INFO_TEST = 1;
   localparam int INFO_BUSY = 2;
   // alert pulse and recovery lengths in ns, with derived cycle counts
   localparam int CRC_PULSE_NS = 200;
   localparam int PAR_HOLD_NS = 2000;
   localparam int CRC_PULSE_CYC = (CRC_PULSE_NS * CLK_MHZ) / 1000;
   localparam int PAR_HOLD_CYC = (PAR_HOLD_NS * CLK_MHZ) / 1000;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CRC_PULSE_CNT = CNT_W'(CRC_PULSE_CYC);
   localparam logic [CNT_W-1:0] PAR_HOLD_CNT = CNT_W'(PAR_HOLD_CYC);
   // alert state machine, one-hot
   typedef enum logic [2:0] {
      AL_IDLE = 3'b001,
      AL_CRC = 3'b010,
      AL_PAR = 3'b100
   } alert_e;
endpackage

/* hdl/ca_parity_alert.sv */
// command/address parity check and shared alert output
// assumes a controller drives cs/ca/par on pclk and a crc checker gives error pulses
// Behaviour
// - parity is checked only when the parity latency field is non-zero.
// - parity covers act, ras/a16, cas/a15, we/a14, bg, ba, a17-a0 and c0-c2, even.
// - only cycles with chip select sampled low are checked.
// - a write crc error drives alert low for a fixed pulse then releases it.
// - a parity error holds alert low until the recovery period ends.
// - in connectivity test mode the alert pin is an input, never driven.
// - connectivity test mode is entered while the test enable input is high.
// - the test enable input is ignored unless the test feature parameter is set.
// - after reset the parity latency field is zero, parity disabled.
// - crc checking is enabled by a control bit; the crc itself is external.
//
// Chosen here: the APB slave port and the register offsets.
module ca_parity_alert
   import ca_parity_alert_pkg::*;
#(
   parameter bit HAS_TEST = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cs_n,
   input wire logic act_n,
   input wire logic [17:0] addr,
   input wire logic [1:0] bg,
   input wire logic [1:0] ba,
   input wire logic [2:0] cid,
   input wire logic par,
   input wire logic crc_error,
   input wire logic test_en,
   input wire logic alert_n_in,
   output logic alert_n_out,
   output logic alert_n_oe_n,
   output logic alert_test_in,
   output logic irq
);

   // register state
   logic [CTRL_PL_W-1:0] par_latency;
   logic crc_enable;
   logic [ST_W-1:0] status;
   logic [ST_W-1:0] mask;
   alert_e state;
   alert_e next_state;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic [2:0] ten_sync;
   logic test_mode;
   logic [2:0] al_sync;

   // apb decode; always ready, unmapped addresses answer with an error
   wire apb_access = psel && penable;
   wire wr_ctrl = apb_access && pwrite && (paddr == ADDR_CTRL);
   wire wr_status = apb_access && pwrite && (paddr == ADDR_STATUS);
   wire wr_mask = apb_access && pwrite && (paddr == ADDR_MASK);
   wire mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                 (paddr == ADDR_MASK) || (paddr == ADDR_INFO);
   assign pready = 1'b1;
   assign pslverr = apb_access && !mapped;

   // even parity over every covered line including par itself
   wire ca_parity_odd = ^{act_n, addr, bg, ba, cid, par};
   wire par_enabled = (par_latency != PL_DISABLED);
   wire par_error = par_enabled && !cs_n && ca_parity_odd;
   // crc error ignored while crc is off
   wire crc_event = crc_enable && crc_error;
   wire [ST_W-1:0] events = {par_error, crc_event};

   // control register; latency field resets to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         par_latency <= PL_DISABLED;
         crc_enable <= 1'b0;
         mask <= '0;
      end else begin
         if (wr_ctrl) begin
            par_latency <= pwdata[CTRL_PL_LSB +: CTRL_PL_W];
            crc_enable <= pwdata[CTRL_CRC_EN];
         end
         if (wr_mask) begin
            mask <= pwdata[ST_W-1:0];
         end
      end
   end

   // sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else begin
         status <= (status & ~(wr_status ? pwdata[ST_W-1:0] : '0)) | events;
      end
   end

   assign irq = |(status & mask);

   // test enable from a pin: three flops, change taken when last two agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ten_sync <= '0;
         test_mode <= 1'b0;
         al_sync <= 3'b111;
      end else begin
         ten_sync <= {ten_sync[1:0], test_en && HAS_TEST};
         if (ten_sync[1] == ten_sync[2]) begin
            test_mode <= ten_sync[2];
         end
         al_sync <= {al_sync[1:0], alert_n_in};
      end
   end

   // alert sequencer; parity recovery outranks a crc pulse
   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         AL_IDLE: begin
            if (par_error) begin
               next_state = AL_PAR;
               next_count = PAR_HOLD_CNT;
            end else if (crc_event) begin
               next_state = AL_CRC;
               next_count = CRC_PULSE_CNT;
            end
         end
         AL_CRC: begin
            if (par_error) begin
               next_state = AL_PAR;
               next_count = PAR_HOLD_CNT;
            end else if (count == CNT_ONE) begin
               next_state = AL_IDLE;
            end else begin
               next_count = count - CNT_ONE;
            end
         end
         AL_PAR: begin
            // errors during recovery just extend nothing; alert stays low
            if (count == CNT_ONE) begin
               next_state = AL_IDLE;
            end else begin
               next_count = count - CNT_ONE;
            end
         end
         default: begin
            next_state = AL_IDLE;
            next_count = '0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= AL_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // pin drive: low only while an error is pending and not in test mode
   wire alert_active = (state != AL_IDLE);
   assign alert_n_out = 1'b0;
   assign alert_n_oe_n = !(alert_active && !test_mode);
   assign alert_test_in = test_mode && !al_sync[2];

   // read mux
   wire [31:0] info = {29'h0, alert_active, test_mode, alert_active && !test_mode};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            ADDR_CTRL: prdata <= {28'h0, crc_enable, par_latency};
            ADDR_STATUS: prdata <= {30'h0, status};
            ADDR_MASK: prdata <= {30'h0, mask};
            ADDR_INFO: prdata <= info;
            default: prdata <= '0;
         endcase
      end
   end

   // run-length counters for the alert checks; the parity hold is too long to unroll
   logic [CNT_W-1:0] par_run;
   logic [CNT_W-1:0] crc_run;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         par_run <= '0;
         crc_run <= '0;
      end else begin
         par_run <= (state == AL_PAR) ? par_run + CNT_ONE : '0;
         crc_run <= (state == AL_CRC) ? crc_run + CNT_ONE : '0;
      end
   end

   // assertions
   property p_no_check_disabled;
      @(posedge pclk) disable iff (!presetn) (par_latency == PL_DISABLED) |-> !par_error;
   endproperty
   a_no_check_disabled: assert property (p_no_check_disabled) else $error("parity checked while off");

   property p_desel;
      @(posedge pclk) disable iff (!presetn) cs_n |-> !par_error;
   endproperty
   a_desel: assert property (p_desel) else $error("deselected cycle checked");
   property p_par_flag;
      @(posedge pclk) disable iff (!presetn) par_error |=> status[ST_PAR];
   endproperty
   a_par_flag: assert property (p_par_flag) else $error("parity flag lost");
   property p_crc_low;
      @(posedge pclk) disable iff (!presetn)
         (state == AL_IDLE && crc_event && !par_error && !test_mode) |=> (!alert_n_oe_n)[*4];
   endproperty
   a_crc_low: assert property (p_crc_low) else $error("crc pulse too short");
   property p_par_low;
      @(posedge pclk) disable iff (!presetn)
         (state == AL_IDLE && par_error) |=> (state == AL_PAR)[*8];
   endproperty
   a_par_low: assert property (p_par_low) else $error("parity hold too short");
   property p_test_release;
      @(posedge pclk) disable iff (!presetn) test_mode |-> alert_n_oe_n;
   endproperty
   a_test_release: assert property (p_test_release) else $error("alert driven in test");
   property p_idle_release;
      @(posedge pclk) disable iff (!presetn) (state == AL_IDLE) |-> alert_n_oe_n;
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("alert low when idle");
   property p_crc_end;
      @(posedge pclk) disable iff (!presetn)
         (state == AL_CRC && count == CNT_ONE && !par_error) |=> (state == AL_IDLE);
   endproperty
   a_crc_end: assert property (p_crc_end) else $error("crc pulse not released");

   // crc event must leave a sticky flag behind
   property p_crc_flag;
      @(posedge pclk) disable iff (!presetn) crc_event |=> status[ST_CRC];
   endproperty
   a_crc_flag: assert property (p_crc_flag) else $error("crc flag lost");

   // whole parity hold, counted outside the property
   property p_par_hold_len;
      @(posedge pclk) disable iff (!presetn)
         (state == AL_PAR && next_state == AL_IDLE) |-> (par_run == PAR_HOLD_CNT - CNT_ONE);
   endproperty
   a_par_hold_len: assert property (p_par_hold_len) else $error("parity hold length");

   // whole crc pulse; a pulse cut by a parity error never reaches idle from here
   property p_crc_pulse_len;
      @(posedge pclk) disable iff (!presetn)
         (state == AL_CRC && next_state == AL_IDLE) |-> (crc_run == CRC_PULSE_CNT - CNT_ONE);
   endproperty
   a_crc_pulse_len: assert property (p_crc_pulse_len) else $error("crc pulse length");

   // an odd selected word must be flagged when checking is on
   property p_odd_detect;
      @(posedge pclk) disable iff (!presetn)
         (par_enabled && !cs_n && ca_parity_odd) |-> par_error;
   endproperty
   a_odd_detect: assert property (p_odd_detect) else $error("odd parity missed");

   // an even word is never an error
   property p_even_clean;
      @(posedge pclk) disable iff (!presetn) !ca_parity_odd |-> !par_error;
   endproperty
   a_even_clean: assert property (p_even_clean) else $error("even parity flagged");

   // latency field held at off while reset is applied
   property p_reset_latency;
      @(posedge pclk) !presetn |-> (par_latency == PL_DISABLED);
   endproperty
   a_reset_latency: assert property (p_reset_latency) else $error("latency not cleared");

   // parity error outside test mode pulls the pin at the next edge
   property p_par_enter;
      @(posedge pclk) disable iff (!presetn) (par_error && !test_mode) |=> !alert_n_oe_n;
   endproperty
   a_par_enter: assert property (p_par_enter) else $error("parity alert not driven");

   // crc input is ignored while crc checking is off
   property p_crc_off;
      @(posedge pclk) disable iff (!presetn) !crc_enable |-> !crc_event;
   endproperty
   a_crc_off: assert property (p_crc_off) else $error("crc taken while off");

   // parity recovery takes over a running crc pulse
   property p_par_outranks;
      @(posedge pclk) disable iff (!presetn) (state == AL_CRC && par_error) |=> (state == AL_PAR);
   endproperty
   a_par_outranks: assert property (p_par_outranks) else $error("parity lost in crc pulse");

   // recovery ends when the count runs out
   property p_par_end;
      @(posedge pclk) disable iff (!presetn)
         (state == AL_PAR && count == CNT_ONE) |=> (state == AL_IDLE);
   endproperty
   a_par_end: assert property (p_par_end) else $error("parity hold not released");

   // sequencer state stays one-hot
   property p_onehot;
      @(posedge pclk) disable iff (!presetn) $onehot(state);
   endproperty
   a_onehot: assert property (p_onehot) else $error("alert state not one-hot");

   // pin input only reported in test mode
   property p_test_in_quiet;
      @(posedge pclk) disable iff (!presetn) !test_mode |-> !alert_test_in;
   endproperty
   a_test_in_quiet: assert property (p_test_in_quiet) else $error("test input outside test");

   // without the feature, test mode never comes up
   property p_ten_gate;
      @(posedge pclk) disable iff (!presetn) !HAS_TEST |-> !test_mode;
   endproperty
   a_ten_gate: assert property (p_ten_gate) else $error("test mode without feature");

   // parity flag sticks until software clears it
   property p_sticky;
      @(posedge pclk) disable iff (!presetn) (status[ST_PAR] && !wr_status) |=> status[ST_PAR];
   endproperty
   a_sticky: assert property (p_sticky) else $error("parity flag dropped");

   // unmapped access answers with an error
   property p_unmapped;
      @(posedge pclk) disable iff (!presetn) (apb_access && !mapped) |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");

   // no flag means no interrupt
   property p_irq_quiet;
      @(posedge pclk) disable iff (!presetn) (status == '0) |-> !irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without flag");

   // main scenarios
   c_par: cover property (@(posedge pclk) disable iff (!presetn) par_error);
   c_par_in_crc: cover property (@(posedge pclk) disable iff (!presetn)
      state == AL_CRC && par_error);
   c_crc: cover property (@(posedge pclk) disable iff (!presetn) crc_event);
   c_test: cover property (@(posedge pclk) disable iff (!presetn) test_mode);
endmodule

/* testbench/ca_ctrl_model.sv */
// controller model driving command, address and parity into the block
// assumes the bench gives run and bad on pclk; bad forces one selected cycle
module ca_ctrl_model (
   input wire logic pclk,
   input wire logic run,
   input wire logic bad,
   output logic cs_n,
   output logic act_n,
   output logic [17:0] addr,
   output logic [1:0] bg,
   output logic [1:0] ba,
   output logic [2:0] cid,
   output logic par
);
   timeunit 1ns;
   timeprecision 1ps;
   integer seed = 32'h2714;
   initial cs_n = 1'b1;
   // fresh pattern every cycle, so idle lines never look stable
   always @(posedge pclk) begin
      logic [31:0] r;
      logic sel;
      r = $random(seed);
      sel = bad | (run & r[31]);
      cs_n <= !sel;
      {act_n, addr, bg, ba, cid} <= r[25:0];
      // even parity when selected without bad, odd when bad; junk parity on deselected cycles
      par <= sel ? (^r[25:0]) ^ bad : r[30];
   end
endmodule

/* testbench/ca_parity_alert_signalling_tb.sv */
// self-checking bench for the parity and alert block
// assumes one pclk domain, apb with pready, and a pull-up on the alert pin
module ca_parity_alert_signalling_tb;
   import ca_parity_alert_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic crc_error = 0, test_en = 0, run = 0, bad = 0, pull_low = 0, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q, d;
   logic pready, pslverr, alert_n_out, alert_n_oe_n, alert_test_in, irq;
   logic cs_n, act_n, par;
   logic [17:0] addr;
   logic [1:0] bg, ba;
   logic [2:0] cid;
   int n_fail = 0, samples_checked = 0, n;
   integer seed = 32'h2714;
   // pin level: driven low by the block, else pulled up unless tester pulls low
   wire pin = !alert_n_oe_n ? alert_n_out : !pull_low;
   always #10 pclk = ~pclk;
   ca_ctrl_model i_ca_ctrl_model (.pclk, .run, .bad, .cs_n, .act_n, .addr, .bg, .ba,
      .cid, .par);
   ca_parity_alert i_ca_parity_alert (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .cs_n, .act_n, .addr, .bg, .ba, .cid, .par,
      .crc_error, .test_en, .alert_n_in(pin), .alert_n_out, .alert_n_oe_n,
      .alert_test_in, .irq);
   task conclude;
      $display("checks %0d fails %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer; waits for pready, result lands in q and err
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // counts driven-low cycles at the falling edge, clear of update races
   task lows;
      n = 0;
      repeat (150) begin
         @(negedge pclk);
         if (alert_n_oe_n === 1'b0) n++;
      end
   endtask
   task pulse_bad;
      @(posedge pclk); bad <= 1'b1;
      @(posedge pclk); bad <= 1'b0;
      lows;
   endtask
   task pulse_crc;
      @(posedge pclk); crc_error <= 1'b1;
      @(posedge pclk); crc_error <= 1'b0;
      lows;
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(alert_n_oe_n, 1);
      apb(0, ADDR_CTRL, 0); chk(q, 0);
      run <= 1'b1;
      pulse_bad; chk(n, 0);
      apb(1, ADDR_MASK, 3);
      apb(1, ADDR_CTRL, 32'h9);
      repeat (200) @(posedge pclk);
      apb(0, ADDR_STATUS, 0); chk(q, 0);
      pulse_bad; chk(n, PAR_HOLD_CYC);
      apb(0, ADDR_STATUS, 0); chk(q, 2);
      chk(irq, 1);
      apb(1, ADDR_STATUS, 2);
      @(negedge pclk); chk(irq, 0);
      pulse_crc; chk(n, CRC_PULSE_CYC);
      apb(0, ADDR_STATUS, 0); chk(q, 1);
      apb(0, 12'h010, 0); chk({err, q[30:0]}, 32'h80000000);
      // random mask values, only the two event bits are kept
      repeat (4) begin
         d = $random(seed);
         apb(1, ADDR_MASK, d);
         apb(0, ADDR_MASK, 0); chk(q, d & 32'h3);
      end
      test_en <= 1'b1;
      pull_low <= 1'b1;
      repeat (6) @(posedge pclk);
      pulse_crc; chk(n, 0);
      chk(alert_test_in, 1);
      apb(0, ADDR_INFO, 0); chk(q, 32'h2);
      conclude;
   end
   // hang guard, far past the expected run length
   initial begin
      repeat (5000) @(posedge pclk);
      n_fail++;
      conclude;
   end
endmodule
